// ===== core/mswv_pkg.sv
// shared constants and types of the microstep wave sequencer
package mswv_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_TABLE0 = 8'h00;
    localparam logic [7:0] OFS_SEGSEL = 8'h20;
    localparam logic [7:0] OFS_START = 8'h24;
    localparam logic [7:0] OFS_CTRL = 8'h28;
    localparam logic [7:0] OFS_COUNT = 8'h2C;
    localparam logic [7:0] OFS_CUR = 8'h30;
    localparam logic [31:0] RST_TABLE_LO = 32'h00000000;
    localparam logic [31:0] RST_TABLE7 = 32'h00404222;
    localparam logic [31:0] RST_SEGSEL = 32'hFFFF8056;
    localparam logic [31:0] RST_START = 32'h00F70000;
    localparam logic [7:0] RST_OFFSET = 8'h00;
    localparam logic [9:0] RST_COUNT = 10'h000;
    localparam logic [9:0] QUARTER_STEPS = 10'h100;
    localparam logic [7:0] OFFSET_MOST_NEG = 8'h80;
    localparam logic [7:0] OFFSET_LIMIT_NEG = 8'h81;
    localparam int CTRL_STEP_BIT = 8;
    localparam int CTRL_DIR_BIT = 9;
    localparam int COIL_B_CURRENT_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // signed coil current, one sign bit above the 8-bit magnitude
    typedef logic signed [8:0] mswv_cur_t;
    typedef logic signed [9:0] mswv_mag_t;
    typedef logic signed [2:0] mswv_inc_t;
    typedef struct packed {
        logic [7:0] x3;
        logic [7:0] x2;
        logic [7:0] x1;
        logic [1:0] w3;
        logic [1:0] w2;
        logic [1:0] w1;
        logic [1:0] w0;
    } mswv_segsel_s;
    typedef struct packed {
        logic [7:0] pad_hi;
        logic [7:0] cos_start;
        logic [7:0] pad_lo;
        logic [7:0] sin_start;
    } mswv_start_s;
    typedef struct packed {
        logic req;
        logic up;
    } mswv_step_s;
    typedef struct packed {
        mswv_cur_t a;
        mswv_cur_t b;
    } mswv_coil_s;
endpackage

// ===== core/mswv_seg_incl.sv
// segment lookup: table position to per-step increment
`timescale 1ns/1ns
`default_nettype none
module mswv_seg_incl
    import mswv_pkg::*;
(
    input wire logic [9:0] lower_pos,
    input wire logic [255:0] table_bits,
    input wire mswv_segsel_s segsel,
    output mswv_inc_t inc
);
    logic [7:0] idx;
    logic [1:0] code;

    // odd quadrants walk the quarter table backwards
    always_comb begin
        idx = lower_pos[8] ? ~lower_pos[7:0] : lower_pos[7:0];
        if (idx < segsel.x1) begin
            code = segsel.w0;
        end else if (idx < segsel.x2) begin
            code = segsel.w1;
        end else if (idx < segsel.x3) begin
            code = segsel.w2;
        end else begin
            code = segsel.w3;
        end
        // code 0..3 means inclination -1..2, table bit adds one
        inc = $signed({1'b0, code}) - 3'sd1
            + $signed({2'b00, table_bits[idx]});
    end
endmodule
`default_nettype wire

// ===== core/mswv_wave_track.sv
// one coil: incremental magnitude tracker with signed output
`timescale 1ns/1ns
`default_nettype none
module mswv_wave_track
    import mswv_pkg::*;
#(
    parameter mswv_mag_t RST_MAG = 10'sd0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic step,
    input wire logic add,
    input wire mswv_inc_t inc,
    input wire logic reload,
    input wire logic [7:0] reload_val,
    input wire logic neg,
    output mswv_mag_t mag,
    output mswv_cur_t cur
);
    mswv_mag_t next_mag;

    // reload beats stepping so drift is cleared at zero
    always_comb begin
        next_mag = mag;
        if (reload) begin
            next_mag = $signed({2'b00, reload_val});
        end else if (step) begin
            next_mag = add ? mag + 10'(inc) : mag - 10'(inc);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mag <= RST_MAG;
        end else begin
            mag <= next_mag;
        end
    end

    // sign from the quadrant the position lands in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur <= 9'(RST_MAG);
        end else begin
            cur <= neg ? 9'(-next_mag) : 9'(next_mag);
        end
    end
endmodule
`default_nettype wire

// ===== core/mswv_top.sv
// microstep wave table sequencer with AXI4-Lite register slave
//
// Contract
// - only the quarter wave is stored, mirrored out to a full turn
// - the 10-bit microstep counter indexes the extended wave
// - 256 incremental table bits live in eight 32-bit words
// - table bit picks inclination or inclination plus one per step
// - base inclination codes give -1, 0, 1 or 2
// - three boundaries split the quarter into four segments
// - every microstep both coil currents are computed and stored
// - both currents reload absolute starts when counter passes zero
// - the sine start value is programmable, not fixed zero
// - a cosine start value serves the 90 degree shifted coil
// - signed offset -127..+127 trims the second coil shift
// - table word seven resets to the default sine pattern
// - segment select resets to boundaries 128, 255, 255
// - default sine positive 768..255, negative 256..767
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module mswv_top
    import mswv_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire mswv_step_s step_in,
    output mswv_coil_s coil_current
);
    logic [31:0] table_word [8];
    logic [255:0] table_bits;
    mswv_segsel_s wave_segment_select;
    mswv_start_s wave_start_values;
    logic [7:0] cosine_phase_offset;
    logic sw_up;
    logic sw_step;
    logic [9:0] microstep_counter;

    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic aw_hs;
    logic w_hs;
    logic wr_go;
    logic [ADDR_W-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic wr_bad;
    logic [31:0] rd_val;
    logic rd_bad;

    logic step_go;
    logic step_up;
    logic [9:0] next_count;
    logic [9:0] pos_b;
    logic [9:0] next_pos_b;
    logic [9:0] lower_a;
    logic [9:0] lower_b;
    logic reload_go;
    logic neg_a;
    logic neg_b;
    mswv_inc_t inc_a;
    mswv_inc_t inc_b;
    mswv_mag_t mag_a;

    // merge write data into a register under the byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // write channel: address and data may arrive in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign wr_go = (aw_held || aw_hs) && (w_held || w_hs);
    assign wa = aw_held ? aw_addr_q : s_axi_awaddr;
    assign wd = w_held ? w_data_q : s_axi_wdata;
    assign ws = w_held ? w_strb_q : s_axi_wstrb;
    assign wr_bad = (wa[1:0] != 2'h0) || (wa > OFS_CUR);

    // hold whichever half came first until its partner shows up
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else begin
            if (aw_hs && !wr_go) begin
                aw_held <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (w_hs && !wr_go) begin
                w_held <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    // write response one cycle after both halves are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_bad ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // table words; read-only offsets ignore writes quietly
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 7; i++) begin
                table_word[i] <= RST_TABLE_LO;
            end
            table_word[7] <= RST_TABLE7;
        end else if (wr_go && !wr_bad && wa < OFS_SEGSEL) begin
            table_word[wa[4:2]] <= merge(table_word[wa[4:2]], wd, ws);
        end
    end

    // flatten the eight words into one 256-bit quarter table
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            table_bits[i*32 +: 32] = table_word[i];
        end
    end

    // segment select and start values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wave_segment_select <= RST_SEGSEL;
            wave_start_values <= RST_START;
        end else if (wr_go && !wr_bad) begin
            if (wa == OFS_SEGSEL) begin
                wave_segment_select <= merge(wave_segment_select, wd, ws);
            end
            if (wa == OFS_START) begin
                wave_start_values <= merge(wave_start_values, wd, ws);
            end
        end
    end

    // control: offset clamps -128 to -127, step bit is a pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cosine_phase_offset <= RST_OFFSET;
            sw_up <= 1'b1;
            sw_step <= 1'b0;
        end else begin
            sw_step <= 1'b0;
            if (wr_go && !wr_bad && wa == OFS_CTRL) begin
                if (ws[0]) begin
                    cosine_phase_offset <= (wd[7:0] == OFFSET_MOST_NEG) ?
                        OFFSET_LIMIT_NEG : wd[7:0];
                end
                if (ws[1]) begin
                    sw_step <= wd[CTRL_STEP_BIT];
                    sw_up <= wd[CTRL_DIR_BIT];
                end
            end
        end
    end

    // read mux over the mapped words
    always_comb begin
        rd_val = 32'h00000000;
        rd_bad = 1'b0;
        if (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > OFS_CUR) begin
            rd_bad = 1'b1;
        end else if (s_axi_araddr < OFS_SEGSEL) begin
            rd_val = table_word[s_axi_araddr[4:2]];
        end else begin
            unique case (s_axi_araddr)
                OFS_SEGSEL: rd_val = wave_segment_select;
                OFS_START: rd_val = wave_start_values;
                OFS_CTRL: rd_val = {22'h0, sw_up, 1'b0,
                    cosine_phase_offset};
                OFS_COUNT: rd_val = {22'h0, microstep_counter};
                default: rd_val = {7'h0, coil_current.b,
                    7'h0, coil_current.a};
            endcase
        end
    end

    // read channel: one outstanding read, data held until taken
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_bad ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // a hardware step wins over a software step in the same cycle
    assign step_go = step_in.req || sw_step;
    assign step_up = step_in.req ? step_in.up : sw_up;
    assign next_count = step_up ? microstep_counter + 10'h001
        : microstep_counter - 10'h001;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            microstep_counter <= RST_COUNT;
        end else if (step_go) begin
            microstep_counter <= next_count;
        end
    end

    // second coil sits a quarter turn ahead, trimmed by the offset;
    // an offset change mid-turn settles at the next zero pass
    assign pos_b = microstep_counter + QUARTER_STEPS
        + {{2{cosine_phase_offset[7]}}, cosine_phase_offset};
    assign next_pos_b = (step_go ? next_count : microstep_counter)
        + QUARTER_STEPS
        + {{2{cosine_phase_offset[7]}}, cosine_phase_offset};
    assign lower_a = step_up ? microstep_counter
        : microstep_counter - 10'h001;
    assign lower_b = step_up ? pos_b : pos_b - 10'h001;
    assign reload_go = step_go && next_count == 10'h000;

    // sine negative for counter 256..767; cosine in quadrants 0,3
    assign neg_a = step_go ? (next_count[9] ^ next_count[8])
        : (microstep_counter[9] ^ microstep_counter[8]);
    assign neg_b = next_pos_b[9] ~^ next_pos_b[8];

    mswv_seg_incl u_incl_a (
        .lower_pos(lower_a),
        .table_bits(table_bits),
        .segsel(wave_segment_select),
        .inc(inc_a)
    );

    mswv_seg_incl u_incl_b (
        .lower_pos(lower_b),
        .table_bits(table_bits),
        .segsel(wave_segment_select),
        .inc(inc_b)
    );

    // magnitudes rise in even quadrants, fall in odd ones
    mswv_wave_track #(
        .RST_MAG(10'(RST_START[7:0]))
    ) u_track_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .step(step_go),
        .add(step_up ^ lower_a[8]),
        .inc(inc_a),
        .reload(reload_go),
        .reload_val(wave_start_values.sin_start),
        .neg(neg_a),
        .mag(mag_a),
        .cur(coil_current.a)
    );

    mswv_wave_track #(
        .RST_MAG(10'(RST_START[23:16]))
    ) u_track_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .step(step_go),
        .add(step_up ^ lower_b[8]),
        .inc(inc_b),
        .reload(reload_go),
        .reload_val(wave_start_values.cos_start),
        .neg(neg_b),
        .mag(),
        .cur(coil_current.b)
    );

    // checks on the sequencer and the bus slave
    sequence s_write_done;
        wr_go ##1 s_axi_bvalid;
    endsequence

    property p_count_step;
        @(posedge aclk) disable iff (!aresetn)
        step_go |=> microstep_counter ==
            ($past(step_up) ? $past(microstep_counter) + 10'h001
            : $past(microstep_counter) - 10'h001);
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("microstep counter did not follow the step");

    property p_reload_a;
        @(posedge aclk) disable iff (!aresetn)
        reload_go |=> coil_current.a ==
            $signed({1'b0, $past(wave_start_values.sin_start)});
    endproperty
    a_reload_a: assert property (p_reload_a)
        else $error("coil a not reloaded at counter zero");

    property p_reload_b;
        @(posedge aclk) disable iff (!aresetn)
        reload_go && cosine_phase_offset == 8'h00 |=>
            coil_current.b ==
            $signed({1'b0, $past(wave_start_values.cos_start)});
    endproperty
    a_reload_b: assert property (p_reload_b)
        else $error("coil b not reloaded with cosine start");

    property p_incremental;
        @(posedge aclk) disable iff (!aresetn)
        step_go && !reload_go |=> mag_a == ($past(step_up ^ lower_a[8])
            ? $past(mag_a) + 10'($past(inc_a))
            : $past(mag_a) - 10'($past(inc_a)));
    endproperty
    a_incremental: assert property (p_incremental)
        else $error("coil a magnitude did not take the step increment");

    property p_sine_sign;
        @(posedge aclk) disable iff (!aresetn)
        ##1 (mag_a >= 0 && microstep_counter >= 10'h100
            && microstep_counter <= 10'h2FF) |-> coil_current.a <= 0;
    endproperty
    a_sine_sign: assert property (p_sine_sign)
        else $error("sine not negative in the lower half turn");

    property p_reset_table;
        @(posedge aclk)
        $rose(aresetn) |-> table_word[7] == RST_TABLE7;
    endproperty
    a_reset_table: assert property (p_reset_table)
        else $error("table word seven lost its reset pattern");

    property p_reset_segsel;
        @(posedge aclk)
        $rose(aresetn) |-> wave_segment_select.x1 == 8'h80
            && wave_segment_select.x2 == 8'hFF
            && wave_segment_select.x3 == 8'hFF
            && wave_segment_select.w0 == 2'h2;
    endproperty
    a_reset_segsel: assert property (p_reset_segsel)
        else $error("segment select reset value wrong");

    property p_offset_range;
        @(posedge aclk) disable iff (!aresetn)
        wr_go && wa == OFS_CTRL && ws[0] && wd[7:0] == 8'h80
            |=> cosine_phase_offset == 8'h81;
    endproperty
    a_offset_range: assert property (p_offset_range)
        else $error("phase offset left the -127..+127 range");

    property p_write_resp;
        @(posedge aclk) disable iff (!aresetn)
        s_write_done |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_write_resp: assert property (p_write_resp)
        else $error("write accepted while response pending");
endmodule
`default_nettype wire

// ===== testbench/mswv_coil_reg_model.sv
// partner model: coil current regulator that also issues microstep pulses
`timescale 1ns/1ns
`default_nettype none
module mswv_coil_reg_model
    import mswv_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic up,
    input wire logic [10:0] n_steps,
    input wire mswv_coil_s coil_current,
    output var mswv_step_s step_in,
    output var logic busy
);
    logic [10:0] left;

    // one step pulse per cycle, held back to back until the count runs out
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            left <= 11'h000;
            step_in <= '0;
            busy <= 1'b0;
        end else if (start && !busy) begin
            left <= n_steps - 11'h001;
            step_in.req <= 1'b1;
            step_in.up <= up;
            busy <= 1'b1;
        end else if (left != 11'h000) begin
            left <= left - 11'h001;
        end else begin
            step_in.req <= 1'b0;
            busy <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/mswv_top_tb.sv
// self-checking bench for the microstep wave sequencer
`timescale 1ns/1ns
`default_nettype none
module mswv_top_tb
    import mswv_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hF;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    mswv_step_s step_in;
    mswv_coil_s coil;
    logic go = 1'b0;
    logic up = 1'b1;
    logic [10:0] n = 11'h001;
    logic busy;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;

    mswv_top uut (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid),
        .s_axi_awready(awready),
        .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid),
        .s_axi_wready(wready),
        .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid),
        .s_axi_bready(bready),
        .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid),
        .s_axi_arready(arready),
        .s_axi_rdata(rdata),
        .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid),
        .s_axi_rready(rready),
        .step_in(step_in),
        .coil_current(coil)
    );

    mswv_coil_reg_model regm (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(go),
        .up(up),
        .n_steps(n),
        .coil_current(coil),
        .step_in(step_in),
        .busy(busy)
    );

    // 250 MHz clock
    always #2 aclk = ~aclk;

    // hang guard, well above the some 1300 cycles the tests need
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_word(input string what, input logic [31:0] e,
                            input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_resp(input string what, input logic [1:0] e,
                            input logic [1:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s resp expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_cur(input string what, input mswv_cur_t e,
                           input mswv_cur_t g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %0d seen %0d", what, e, g);
        end
    endtask

    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic ah;
        logic wh;
        ah = 1'b1;
        wh = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (!ah && !wh && bvalid === 1'b1) begin
                bready <= 1'b0;
                chk_resp("write", er, bresp);
                break;
            end
            if (ah && awready === 1'b1) begin
                ah = 1'b0;
                awvalid <= 1'b0;
            end
            if (wh && wready === 1'b1) begin
                wh = 1'b0;
                wvalid <= 1'b0;
            end
        end
    endtask

    // read and compare data and response
    task automatic rdc(input string what, input logic [7:0] a,
                       input logic [31:0] ed, input logic [1:0] er);
        logic ah;
        ah = 1'b1;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (!ah && rvalid === 1'b1) begin
                rready <= 1'b0;
                chk_word(what, ed, rdata);
                chk_resp(what, er, rresp);
                break;
            end
            if (ah && arready === 1'b1) begin
                ah = 1'b0;
                arvalid <= 1'b0;
            end
        end
    endtask

    // hardware steps through the partner, sampled once settled
    task automatic steps(input logic dir, input logic [10:0] cnt);
        @(posedge aclk);
        up <= dir;
        n <= cnt;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        @(negedge aclk);
        while (busy !== 1'b0) @(negedge aclk);
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rdc("table7", 8'h1C, 32'h00404222, 2'h0);
        rdc("segsel", 8'h20, 32'hFFFF8056, 2'h0);
        rdc("start", 8'h24, 32'h00F70000, 2'h0);
        rdc("ctrl", 8'h28, 32'h00000200, 2'h0);
        rdc("coils", 8'h30, 32'h00F70000, 2'h0);
        chk_cur("coil b", 9'h0F7, coil.b);
        $display("reset test done");
        wr(8'h00, 32'hA5A5A5A5, 2'h0);
        rdc("table0", 8'h00, 32'hA5A5A5A5, 2'h0);
        wr(8'h2C, 32'h00000055, 2'h0);
        rdc("count ro", 8'h2C, 32'h00000000, 2'h0);
        wr(8'h40, 32'h00000001, RESP_SLVERR);
        rdc("unmapped", 8'h34, 32'h00000000, RESP_SLVERR);
        rdc("unaligned", 8'h21, 32'h00000000, RESP_SLVERR);
        $display("bus test done");
        // small custom wave: four ones at positions 0..3
        wr(8'h00, 32'h0000000F, 2'h0);
        for (int c = 0; c < 4; c++) begin
            wr(8'h20, {24'hFFFFFF, 6'h15, c[1:0]}, 2'h0);
            steps(1'b1, 11'h008);
            chk_cur("incl", 9'(8 * (c - 1) + 4), coil.a);
            steps(1'b0, 11'h008);
            chk_cur("reload", 9'h000, coil.a);
        end
        wr(8'h00, 32'h00000000, 2'h0);
        wr(8'h20, 32'hFFFF045E, 2'h0);
        steps(1'b1, 11'h008);
        chk_cur("boundary", 9'h00C, coil.a);
        steps(1'b0, 11'h008);
        wr(8'h24, 32'h00F70002, 2'h0);
        steps(1'b1, 11'h001);
        steps(1'b0, 11'h001);
        chk_cur("sine start", 9'h002, coil.a);
        wr(8'h24, 32'h00F70000, 2'h0);
        wr(8'h20, 32'hFFFF8056, 2'h0);
        $display("table test done");
        // wrap below zero, then one full turn on the default wave
        steps(1'b0, 11'h001);
        rdc("count wrap", 8'h2C, 32'h000003FF, 2'h0);
        steps(1'b1, 11'h001);
        chk_cur("restart", 9'h000, coil.a);
        steps(1'b1, 11'h12C);
        chk_word("sine sign", 32'h1, {31'h0, coil.a[8]});
        chk_word("cos sign", 32'h0, {31'h0, coil.b[8]});
        steps(1'b1, 11'h12C);
        chk_word("sine sign", 32'h1, {31'h0, coil.a[8]});
        chk_word("cos sign", 32'h1, {31'h0, coil.b[8]});
        steps(1'b1, 11'h1A8);
        rdc("turn", 8'h30, 32'h00F70000, 2'h0);
        $display("turn test done");
        wr(8'h28, 32'h00000280, 2'h0);
        rdc("offset clamp", 8'h28, 32'h00000281, 2'h0);
        wr(8'h28, 32'h0000027F, 2'h0);
        rdc("offset max", 8'h28, 32'h0000027F, 2'h0);
        wr(8'h28, 32'h0000027E, 2'h0);
        rdc("offset trim", 8'h28, 32'h0000027E, 2'h0);
        wr(8'h28, 32'h00000300, 2'h0);
        rdc("sw step", 8'h2C, 32'h00000001, 2'h0);
        wr(8'h28, 32'h00000100, 2'h0);
        rdc("sw step down", 8'h2C, 32'h00000000, 2'h0);
        $display("control test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
